// ==== include/slbcu_regs.svh ====
// Named offsets, field positions, encodings and reset values of the shift, logic, bit and compare unit
//
// What this block does
// (RQ1) Checked left shift saturates, flags overflow
// (RQ2) Arithmetic right shift replicates sign bit
// (RQ3) Rounding right shift rounds toward zero
// (RQ4) Rotate left wraps bit 31 to 0
// (RQ5) Pair shift right, low word kept
// (RQ6) Eleven bitwise Boolean functions provided
// (RQ7) Set, clear or toggle one bit
// (RQ8) Alter bit follows condition code
// (RQ9) Find most significant set/clear bit
// (RQ10) Search miss gives all ones, false
// (RQ11) Extract right-justifies field, zero above
// (RQ12) Merge source bits under mask only
// (RQ13) Byte match sets condition code
// (RQ14) Compares set less, equal, greater
// (RQ15) Less 100, equal 010, greater 001
// (RQ16) Guarded compare skipped when bit 2 set
// (RQ17) Bit test gives true or false
// (RQ18) Compare then step in one cycle
// (RQ19) Condition test writes one or zero
// (RQ20) Prediction bit never changes result
// (RQ21) Overflow faults or sets flag per mask
`ifndef SLBCU_REGS_SVH
`define SLBCU_REGS_SVH

// ********************************
// Register map
// ********************************
`define SLBCU_ACR_ADDR      4'h0
`define SLBCU_ACR_RESET     32'h0000_0000
`define SLBCU_ACR_WMASK     32'h0000_1107
`define SLBCU_CC_LSB        0
`define SLBCU_CC_MSB        2
`define SLBCU_CC_GUARD_BIT  2
`define SLBCU_OVF_FLAG_BIT  8
`define SLBCU_OVF_MASK_BIT  12

// ********************************
// Condition code values and constants
// ********************************
`define SLBCU_CC_LESS       3'h4
`define SLBCU_CC_EQUAL      3'h2
`define SLBCU_CC_GREATER    3'h1
`define SLBCU_CC_TRUE       3'h2
`define SLBCU_CC_FALSE      3'h0
`define SLBCU_TEST_TRUE     32'h0000_0001
`define SLBCU_TEST_FALSE    32'h0000_0000
`define SLBCU_ALL_ONES      32'hFFFF_FFFF
`define SLBCU_ZERO          32'h0000_0000
`define SLBCU_ONE           32'h0000_0001
`define SLBCU_FULL_SHIFT    6'h20

`endif

// ==== include/slbcu_pkg.sv ====
// Types shared by the unit and its users
`default_nettype none
package slbcu_pkg;

    typedef enum logic [5:0] {
        OP_SHLO, OP_SHRO, OP_SHLI, OP_SHRI, OP_SHRDI, OP_ROTATE, OP_PAIR_SHR,
        OP_AND, OP_NOTAND, OP_ANDNOT, OP_XOR, OP_OR, OP_NOR, OP_XNOR, OP_NOT,
        OP_NOTOR, OP_ORNOT, OP_NAND,
        OP_SETBIT, OP_CLRBIT, OP_NOTBIT, OP_ALTERBIT, OP_SCANBIT, OP_SPANBIT,
        OP_EXTRACT, OP_MODIFY, OP_SCANBYTE,
        OP_CMPI, OP_CMPO, OP_CONCMPI, OP_CONCMPO, OP_CHKBIT,
        OP_CMPINCI, OP_CMPINCO, OP_CMPDECI, OP_CMPDECO, OP_TEST
    } slbcu_op_e;

    typedef struct packed {
        logic        valid;
        slbcu_op_e   op;
        logic [31:0] src1;
        logic [31:0] src2;
        logic [31:0] src3;
        logic [2:0]  condMask;
        logic        predict;
    } slbcu_req_s;

    typedef struct packed {
        logic        valid;
        logic        wrEn;
        logic [31:0] data;
    } slbcu_res_s;

endpackage : slbcu_pkg
`default_nettype wire

// ==== design/slbcu_top.sv ====
// Shift, logic, bit-field and compare execution unit with its arithmetic controls register
`default_nettype none
`include "slbcu_regs.svh"

module slbcu_top #(
    parameter int ADDR_W = 4
) (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire slbcu_pkg::slbcu_req_s req,
    output var  slbcu_pkg::slbcu_res_s res,
    output logic                     ovfFault,
    input  wire logic [ADDR_W-1:0]   regAddr,
    input  wire logic [31:0]         regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic [31:0]              regRdData
);

    // ********************************
    // Helper functions
    // ********************************

    // Largest left shift that keeps the signed value intact
    function automatic logic [5:0] safeLeft(input logic [31:0] v);
        logic [5:0] best;
        best = 6'h00;
        for (int k = 1; k < 32; k++)
        begin
            if ((($signed(v << k)) >>> k) == $signed(v) && best == 6'(k - 1))
                best = 6'(k);
        end
        if (v == `SLBCU_ZERO)
            best = `SLBCU_FULL_SHIFT;
        return best;
    endfunction

    // Position of the highest one; all ones when absent
    function automatic logic [31:0] topOne(input logic [31:0] v);
        logic [31:0] pos;
        pos = `SLBCU_ALL_ONES;
        for (int i = 0; i < 32; i++)
        begin
            if (v[i])
                pos = 32'(i);
        end
        return pos;
    endfunction

    // Three-way compare encoded as a condition code
    function automatic logic [2:0] cmp3(input logic [31:0] a, input logic [31:0] b, input logic sgn);
        logic lt;
        lt = sgn ? ($signed(a) < $signed(b)) : (a < b);
        if (a == b)
            return `SLBCU_CC_EQUAL;
        else if (lt)
            return `SLBCU_CC_LESS;
        else
            return `SLBCU_CC_GREATER;
    endfunction

    // ********************************
    // Architectural state
    // ********************************
    logic [2:0]  ccReg;
    logic        ovfFlagReg;
    logic        ovfMaskReg;
    logic [31:0] acrView;

    assign acrView = {19'h0, ovfMaskReg, 3'h0, ovfFlagReg, 5'h0, ccReg};

    // ********************************
    // Operation decode and datapath
    // ********************************
    logic [31:0] dataNext;
    logic        wrNext;
    logic [2:0]  ccNext;
    logic        ccUpd;
    logic        ovfHit;
    logic [5:0]  cnt;
    logic [4:0]  bitSel;
    logic [31:0] bitMask;
    logic [5:0]  safe;
    logic [31:0] lostBits;
    logic [63:0] pairVal;
    logic [63:0] rotVal;
    logic [31:0] fieldMask;
    logic [32:0] stepSum;

    // Counts of 32 or more are held at 32, a whole-word shift
    assign cnt       = (req.src1 > 32'h0000_001F) ? `SLBCU_FULL_SHIFT : req.src1[5:0];
    assign bitSel    = req.src1[4:0];
    assign bitMask   = `SLBCU_ONE << bitSel;
    assign safe      = safeLeft(req.src2);
    assign lostBits  = req.src2 & ~(`SLBCU_ALL_ONES << cnt);
    assign pairVal   = {req.src3, req.src2} >> cnt;
    assign rotVal    = {req.src2, req.src2} << bitSel;
    assign fieldMask = ~(`SLBCU_ALL_ONES << (req.src2 > 32'h0000_001F ? `SLBCU_FULL_SHIFT : req.src2[5:0]));

    always_comb
    begin
        dataNext = `SLBCU_ZERO;
        wrNext   = 1'b1;
        ccNext   = ccReg;
        ccUpd    = 1'b0;
        ovfHit   = 1'b0;
        stepSum  = 33'h0;
        unique case (req.op)
            slbcu_pkg::OP_SHLO:   dataNext = req.src2 << cnt;
            slbcu_pkg::OP_SHRO:   dataNext = req.src2 >> cnt;
            // (RQ1) saturating left shift
            slbcu_pkg::OP_SHLI:
            begin
                if (cnt <= safe)
                    dataNext = req.src2 << cnt;
                else
                begin
                    dataNext = req.src2 << safe;
                    ovfHit   = 1'b1;
                end
            end
            // (RQ2) sign fill shift
            slbcu_pkg::OP_SHRI:   dataNext = 32'($signed(req.src2) >>> cnt);
            // (RQ3) round toward zero
            slbcu_pkg::OP_SHRDI:
                dataNext = 32'($signed(req.src2) >>> cnt)
                         + ((req.src2[31] && lostBits != `SLBCU_ZERO) ? `SLBCU_ONE : `SLBCU_ZERO);
            // (RQ4) rotate toward msb
            slbcu_pkg::OP_ROTATE: dataNext = rotVal[63:32];
            // (RQ5) pair right shift
            slbcu_pkg::OP_PAIR_SHR: dataNext = pairVal[31:0];
            // (RQ6) bitwise functions
            slbcu_pkg::OP_AND:    dataNext = req.src2 & req.src1;
            slbcu_pkg::OP_NOTAND: dataNext = ~req.src2 & req.src1;
            slbcu_pkg::OP_ANDNOT: dataNext = req.src2 & ~req.src1;
            slbcu_pkg::OP_XOR:    dataNext = req.src2 ^ req.src1;
            slbcu_pkg::OP_OR:     dataNext = req.src2 | req.src1;
            slbcu_pkg::OP_NOR:    dataNext = ~(req.src2 | req.src1);
            slbcu_pkg::OP_XNOR:   dataNext = ~(req.src2 ^ req.src1);
            slbcu_pkg::OP_NOT:    dataNext = ~req.src1;
            slbcu_pkg::OP_NOTOR:  dataNext = ~req.src2 | req.src1;
            slbcu_pkg::OP_ORNOT:  dataNext = req.src2 | ~req.src1;
            slbcu_pkg::OP_NAND:   dataNext = ~(req.src2 & req.src1);
            // (RQ7) single bit edits
            slbcu_pkg::OP_SETBIT: dataNext = req.src2 | bitMask;
            slbcu_pkg::OP_CLRBIT: dataNext = req.src2 & ~bitMask;
            slbcu_pkg::OP_NOTBIT: dataNext = req.src2 ^ bitMask;
            // (RQ8) bit follows condition
            slbcu_pkg::OP_ALTERBIT:
            begin
                if (ccReg == `SLBCU_CC_TRUE)
                    dataNext = req.src2 | bitMask;
                else if (ccReg == `SLBCU_CC_FALSE)
                    dataNext = req.src2 & ~bitMask;
                else
                    dataNext = req.src2;
            end
            // (RQ9) (RQ10) top bit search
            slbcu_pkg::OP_SCANBIT, slbcu_pkg::OP_SPANBIT:
            begin
                dataNext = topOne(req.op == slbcu_pkg::OP_SCANBIT ? req.src1 : ~req.src1);
                ccUpd    = 1'b1;
                ccNext   = (dataNext == `SLBCU_ALL_ONES) ? `SLBCU_CC_FALSE : `SLBCU_CC_TRUE;
            end
            // (RQ11) field extract
            slbcu_pkg::OP_EXTRACT: dataNext = (req.src3 >> bitSel) & fieldMask;
            // (RQ12) masked merge
            slbcu_pkg::OP_MODIFY:  dataNext = (req.src2 & req.src1) | (req.src3 & ~req.src1);
            // (RQ13) byte match
            slbcu_pkg::OP_SCANBYTE:
            begin
                wrNext = 1'b0;
                ccUpd  = 1'b1;
                ccNext = `SLBCU_CC_FALSE;
                for (int b = 0; b < 4; b++)
                begin
                    if (req.src1[b*8 +: 8] == req.src2[b*8 +: 8])
                        ccNext = `SLBCU_CC_TRUE;
                end
            end
            // (RQ14) (RQ15) plain compares
            slbcu_pkg::OP_CMPI, slbcu_pkg::OP_CMPO:
            begin
                wrNext = 1'b0;
                ccUpd  = 1'b1;
                ccNext = cmp3(req.src1, req.src2, req.op == slbcu_pkg::OP_CMPI);
            end
            // (RQ16) guarded compare skip
            slbcu_pkg::OP_CONCMPI, slbcu_pkg::OP_CONCMPO:
            begin
                wrNext = 1'b0;
                ccUpd  = !ccReg[`SLBCU_CC_GUARD_BIT];
                ccNext = ccUpd ? cmp3(req.src1, req.src2, req.op == slbcu_pkg::OP_CONCMPI) : ccReg;
            end
            // (RQ17) selected bit test
            slbcu_pkg::OP_CHKBIT:
            begin
                wrNext = 1'b0;
                ccUpd  = 1'b1;
                ccNext = req.src2[bitSel] ? `SLBCU_CC_TRUE : `SLBCU_CC_FALSE;
            end
            // (RQ18) compare and step together
            slbcu_pkg::OP_CMPINCI, slbcu_pkg::OP_CMPINCO, slbcu_pkg::OP_CMPDECI, slbcu_pkg::OP_CMPDECO:
            begin
                ccUpd  = 1'b1;
                ccNext = cmp3(req.src1, req.src2,
                              req.op == slbcu_pkg::OP_CMPINCI || req.op == slbcu_pkg::OP_CMPDECI);
                if (req.op == slbcu_pkg::OP_CMPINCI || req.op == slbcu_pkg::OP_CMPINCO)
                    stepSum = {1'b0, req.src2} + 33'h1;
                else
                    stepSum = {1'b0, req.src2} - 33'h1;
                dataNext = stepSum[31:0];
                if (req.op == slbcu_pkg::OP_CMPINCI)
                    ovfHit = !req.src2[31] && dataNext[31];
                if (req.op == slbcu_pkg::OP_CMPDECI)
                    ovfHit = req.src2[31] && !dataNext[31];
            end
            // (RQ19) (RQ20) condition test, hint ignored
            slbcu_pkg::OP_TEST:
            begin
                if (req.condMask == `SLBCU_CC_FALSE)
                    dataNext = (ccReg == `SLBCU_CC_FALSE) ? `SLBCU_TEST_TRUE : `SLBCU_TEST_FALSE;
                else
                    dataNext = ((ccReg & req.condMask) != 3'h0) ? `SLBCU_TEST_TRUE : `SLBCU_TEST_FALSE;
            end
            default:
            begin
                wrNext = 1'b0;
            end
        endcase
    end

    // ********************************
    // Result and fault registers
    // ********************************

    // Result stands for one cycle after each accepted request
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            res <= '0;
        end
        else
        begin
            res.valid <= req.valid;
            res.wrEn  <= req.valid && wrNext;
            res.data  <= dataNext;
        end
    end

    // (RQ21) fault only when unmasked
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ovfFault <= 1'b0;
        else
            ovfFault <= req.valid && ovfHit && !ovfMaskReg;
    end

    // ********************************
    // Arithmetic controls register
    // ********************************

    // Condition code: an executing operation wins over a software write
    // Reset values are cut to the field width on purpose
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ccReg <= 3'(`SLBCU_ACR_RESET >> `SLBCU_CC_LSB);
        else if (req.valid && ccUpd)
            ccReg <= ccNext;
        else if (regWr && regAddr == ADDR_W'(`SLBCU_ACR_ADDR))
            ccReg <= regWrData[`SLBCU_CC_MSB:`SLBCU_CC_LSB];
    end

    // (RQ21) sticky flag when masked, set beats clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ovfFlagReg <= 1'(`SLBCU_ACR_RESET >> `SLBCU_OVF_FLAG_BIT);
        else if (req.valid && ovfHit && ovfMaskReg)
            ovfFlagReg <= 1'b1;
        else if (regWr && regAddr == ADDR_W'(`SLBCU_ACR_ADDR))
            ovfFlagReg <= regWrData[`SLBCU_OVF_FLAG_BIT];
    end

    // Mask is software owned
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ovfMaskReg <= 1'(`SLBCU_ACR_RESET >> `SLBCU_OVF_MASK_BIT);
        else if (regWr && regAddr == ADDR_W'(`SLBCU_ACR_ADDR))
            ovfMaskReg <= regWrData[`SLBCU_OVF_MASK_BIT];
    end

    // Read data one cycle after the strobe, zero elsewhere and for unmapped addresses
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            regRdData <= `SLBCU_ZERO;
        else if (regRd && regAddr == ADDR_W'(`SLBCU_ACR_ADDR))
            regRdData <= acrView;
        else
            regRdData <= `SLBCU_ZERO;
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_shliSat;
        req.valid && req.op == slbcu_pkg::OP_SHLI && cnt > safe && !ovfMaskReg
        |=> ovfFault && res.data == ($past(req.src2) << $past(safe));
    endproperty
    a_shliSat: assert property (p_shliSat) else $error("checked left shift did not saturate and fault"); // RQ1

    property p_shri;
        req.valid && req.op == slbcu_pkg::OP_SHRI && cnt == 6'h01
        |=> res.data == {$past(req.src2[31]), $past(req.src2[31:1])};
    endproperty
    a_shri: assert property (p_shri) else $error("arithmetic shift lost the sign"); // RQ2

    property p_shrdiRound;
        req.valid && req.op == slbcu_pkg::OP_SHRDI && cnt == 6'h01 && req.src2[31] && req.src2[0]
        |=> res.data == {$past(req.src2[31]), $past(req.src2[31:1])} + `SLBCU_ONE;
    endproperty
    a_shrdiRound: assert property (p_shrdiRound) else $error("rounding shift did not round toward zero"); // RQ3

    property p_rotate;
        req.valid && req.op == slbcu_pkg::OP_ROTATE && bitSel == 5'h01
        |=> res.data == {$past(req.src2[30:0]), $past(req.src2[31])};
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate did not wrap the top bit"); // RQ4

    property p_scanMiss;
        req.valid && req.op == slbcu_pkg::OP_SCANBIT && req.src1 == `SLBCU_ZERO
        |=> res.data == `SLBCU_ALL_ONES && ccReg == `SLBCU_CC_FALSE;
    endproperty
    a_scanMiss: assert property (p_scanMiss) else $error("empty search gave wrong answer"); // RQ10

    property p_modify;
        req.valid && req.op == slbcu_pkg::OP_MODIFY
        |=> ((res.data ^ $past(req.src3)) & ~$past(req.src1)) == `SLBCU_ZERO;
    endproperty
    a_modify: assert property (p_modify) else $error("merge touched unmasked bits"); // RQ12

    property p_cmpEqual;
        req.valid && req.op == slbcu_pkg::OP_CMPO && req.src1 == req.src2
        |=> ccReg == `SLBCU_CC_EQUAL && !res.wrEn;
    endproperty
    a_cmpEqual: assert property (p_cmpEqual) else $error("equal compare gave wrong code"); // RQ15

    property p_guard;
        req.valid && (req.op == slbcu_pkg::OP_CONCMPI || req.op == slbcu_pkg::OP_CONCMPO)
        && ccReg[`SLBCU_CC_GUARD_BIT] && !regWr
        |=> $stable(ccReg);
    endproperty
    a_guard: assert property (p_guard) else $error("guarded compare changed the code"); // RQ16

    property p_test;
        req.valid && req.op == slbcu_pkg::OP_TEST && req.condMask == ccReg && ccReg != `SLBCU_CC_FALSE
        |=> res.data == `SLBCU_TEST_TRUE && res.wrEn;
    endproperty
    a_test: assert property (p_test) else $error("matching test did not store one"); // RQ19

    property p_maskedFlag;
        req.valid && ovfHit && ovfMaskReg
        |=> !ovfFault && ovfFlagReg;
    endproperty
    a_maskedFlag: assert property (p_maskedFlag) else $error("masked overflow did not set the flag"); // RQ21

endmodule // slbcu_top
`default_nettype wire

// ==== tb/slbcu_issuer.sv ====
// Stand-in for the decoder and register file that issue requests to the unit
`default_nettype none
module slbcu_issuer (
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire slbcu_pkg::slbcu_req_s cmd,
    output var  slbcu_pkg::slbcu_req_s req
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********************************
    // Issue stage
    // ********************************
    // Registered like a decode stage, so requests always change just after an edge
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            req <= '0;
        else
            req <= cmd;
    end
endmodule // slbcu_issuer
`default_nettype wire

// ==== tb/tb_shift_logic_bit_compare_unit.sv ====
// Self-checking bench for the shift, logic, bit and compare unit
`default_nettype none
`include "slbcu_regs.svh"
module tb_shift_logic_bit_compare_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  sys_clk = 1'b0;
    logic                  srst = 1'b1;
    slbcu_pkg::slbcu_req_s cmd = '0;
    slbcu_pkg::slbcu_req_s req;
    slbcu_pkg::slbcu_res_s res;
    logic                  ovfFault;
    logic [3:0]            regAddr = 4'h0;
    logic [31:0]           regWrData = 32'h0;
    logic                  regWr = 1'b0;
    logic                  regRd = 1'b0;
    logic [31:0]           regRdData;
    logic [31:0]           rdVal;
    int                    failures = 0;
    int                    cmpCount = 0;
    // ********************************
    // Clock, partner and unit
    // ********************************
    always #5 sys_clk = ~sys_clk;
    slbcu_issuer slbcu_issuer_i (.sys_clk(sys_clk), .srst(srst), .cmd(cmd), .req(req));
    slbcu_top #(.ADDR_W(4)) slbcu_top_i (.sys_clk(sys_clk), .srst(srst), .req(req), .res(res),
        .ovfFault(ovfFault), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData));
    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Result lands two edges after staging: one for the issue stage, one for the unit
    task automatic op(input slbcu_pkg::slbcu_op_e o, input logic [31:0] a, b, c,
                      input logic [2:0] m = 3'h0, input logic p = 1'b0);
        @(posedge sys_clk);
        cmd <= '{1'b1, o, a, b, c, m, p};
        @(posedge sys_clk);
        cmd.valid <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("res.valid", {31'h0, res.valid}, 32'h1);
    endtask
    task automatic opd(input slbcu_pkg::slbcu_op_e o, input logic [31:0] a, b, c, exp);
        op(o, a, b, c);
        chk(o.name(), res.data, exp);
        chk("res.wrEn", {31'h0, res.wrEn}, 32'h1);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic ccIs(input logic [2:0] e);
        rd(4'h0);
        chk("cc", {29'h0, rdVal[2:0]}, {29'h0, e});
    endtask
    // Flag-only operations must not write the destination
    task automatic opc(input slbcu_pkg::slbcu_op_e o, input logic [31:0] a, b, input logic [2:0] e);
        op(o, a, b, 32'h0);
        chk("res.wrEn", {31'h0, res.wrEn}, 32'h0);
        ccIs(e);
    endtask
    // ********************************
    // Scenarios
    // ********************************
    // controls register reset value and writable bits
    task automatic t_regs;
        rd(4'h0);
        chk("acrReset", rdVal, `SLBCU_ACR_RESET);
        wr(4'h0, `SLBCU_ALL_ONES);
        rd(4'h0);
        chk("acrMask", rdVal, `SLBCU_ACR_WMASK);
        wr(4'h5, `SLBCU_ALL_ONES);
        rd(4'h5);
        chk("unmapped", rdVal, 32'h0);
        wr(4'h0, 32'h0);
    endtask
    // shifts, rounding, rotate and pair shift
    task automatic t_shift;
        opd(slbcu_pkg::OP_SHLO, 32'h4, 32'h12345678, 32'h0, 32'h23456780);
        opd(slbcu_pkg::OP_SHRO, 32'h4, 32'h87654321, 32'h0, 32'h08765432);
        opd(slbcu_pkg::OP_SHRI, 32'h1, 32'hFFFFFFF9, 32'h0, 32'hFFFFFFFC);
        opd(slbcu_pkg::OP_SHRI, 32'h20, 32'h80000000, 32'h0, 32'hFFFFFFFF);
        opd(slbcu_pkg::OP_SHRDI, 32'h1, 32'hFFFFFFF9, 32'h0, 32'hFFFFFFFD);
        opd(slbcu_pkg::OP_SHRDI, 32'h2, 32'hFFFFFFF8, 32'h0, 32'hFFFFFFFE);
        opd(slbcu_pkg::OP_SHRDI, 32'h2, 32'h7, 32'h0, 32'h1);
        opd(slbcu_pkg::OP_ROTATE, 32'h1, 32'h80000001, 32'h0, 32'h3);
        opd(slbcu_pkg::OP_ROTATE, 32'h4, 32'h12345678, 32'h0, 32'h23456781);
        opd(slbcu_pkg::OP_PAIR_SHR, 32'h8, 32'h9ABCDEF0, 32'h12345678, 32'h789ABCDE);
        opd(slbcu_pkg::OP_PAIR_SHR, 32'h20, 32'h9ABCDEF0, 32'h12345678, 32'h12345678);
    endtask
    // saturating shift, fault when unmasked, flag when masked
    task automatic t_ovf;
        op(slbcu_pkg::OP_SHLI, 32'h2, 32'h20000000, 32'h0);
        chk("shliSat", res.data, 32'h40000000);
        chk("fault", {31'h0, ovfFault}, 32'h1);
        rd(4'h0);
        chk("flagClear", rdVal & 32'h1100, 32'h0);
        op(slbcu_pkg::OP_CMPINCI, 32'h0, 32'h7FFFFFFF, 32'h0);
        chk("incWrap", res.data, 32'h80000000);
        chk("incFault", {31'h0, ovfFault}, 32'h1);
        wr(4'h0, 32'h1000);
        op(slbcu_pkg::OP_SHLI, 32'h2, 32'h20000000, 32'h0);
        chk("fault", {31'h0, ovfFault}, 32'h0);
        rd(4'h0);
        chk("flagSet", rdVal & 32'h1100, 32'h1100);
        opd(slbcu_pkg::OP_SHLI, 32'h4, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFF0);
        wr(4'h0, 32'h0);
    endtask
    // all eleven Boolean functions in enum order
    task automatic t_logic;
        logic [31:0]          e [11] = '{32'h000000FF, 32'h0000FF00, 32'h00FF0000, 32'h00FFFF00,
            32'h00FFFFFF, 32'hFF000000, 32'hFF0000FF, 32'hFFFF0000, 32'hFF00FFFF, 32'hFFFF00FF, 32'hFFFFFF00};
        slbcu_pkg::slbcu_op_e o = slbcu_pkg::OP_AND;
        for (int i = 0; i < 11; i++)
        begin
            opd(o, 32'h0000FFFF, 32'h00FF00FF, 32'h0, e[i]);
            o = o.next();
        end
    endtask
    // single-bit edits, tests and condition-driven writes
    task automatic t_bits;
        opd(slbcu_pkg::OP_SETBIT, 32'h1F, 32'h0, 32'h0, 32'h80000000);
        opd(slbcu_pkg::OP_CLRBIT, 32'h0, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFE);
        opd(slbcu_pkg::OP_NOTBIT, 32'h4, 32'h10, 32'h0, 32'h0);
        opc(slbcu_pkg::OP_CHKBIT, 32'h5, 32'h20, `SLBCU_CC_TRUE);
        opd(slbcu_pkg::OP_ALTERBIT, 32'h3, 32'h0, 32'h0, 32'h8);
        opc(slbcu_pkg::OP_CHKBIT, 32'h5, 32'hFFFFFFDF, `SLBCU_CC_FALSE);
        opd(slbcu_pkg::OP_ALTERBIT, 32'h3, 32'hFF, 32'h0, 32'hF7);
    endtask
    // searches, field extract, merge and byte match
    task automatic t_field;
        opd(slbcu_pkg::OP_SCANBIT, 32'h12345, 32'h0, 32'h0, 32'h10);
        ccIs(`SLBCU_CC_TRUE);
        opd(slbcu_pkg::OP_SCANBIT, 32'h0, 32'h0, 32'h0, `SLBCU_ALL_ONES);
        ccIs(`SLBCU_CC_FALSE);
        opd(slbcu_pkg::OP_SPANBIT, 32'hFFFF7FFF, 32'h0, 32'h0, 32'hF);
        opd(slbcu_pkg::OP_SPANBIT, 32'hFFFFFFFF, 32'h0, 32'h0, `SLBCU_ALL_ONES);
        opd(slbcu_pkg::OP_EXTRACT, 32'h4, 32'h8, 32'hABCDEF12, 32'hF1);
        opd(slbcu_pkg::OP_EXTRACT, 32'h1C, 32'h8, 32'hABCDEF12, 32'hA);
        opd(slbcu_pkg::OP_MODIFY, 32'hFF00, 32'h12345678, 32'hAAAAAAAA, 32'hAAAA56AA);
        opc(slbcu_pkg::OP_SCANBYTE, 32'h11223344, 32'h55663377, `SLBCU_CC_TRUE);
        opc(slbcu_pkg::OP_SCANBYTE, 32'h11223344, 32'h44332211, `SLBCU_CC_FALSE);
    endtask
    task automatic t_cmp;
        opc(slbcu_pkg::OP_CMPI, 32'hFFFFFFFF, 32'h1, `SLBCU_CC_LESS);
        opc(slbcu_pkg::OP_CMPO, 32'hFFFFFFFF, 32'h1, `SLBCU_CC_GREATER);
        opc(slbcu_pkg::OP_CMPI, 32'h1, 32'hFFFFFFFF, `SLBCU_CC_GREATER);
        opc(slbcu_pkg::OP_CMPO, 32'h5, 32'h5, `SLBCU_CC_EQUAL);
        opc(slbcu_pkg::OP_CONCMPO, 32'h9, 32'h1, `SLBCU_CC_GREATER);
        opc(slbcu_pkg::OP_CMPO, 32'h1, 32'h9, `SLBCU_CC_LESS);
        opd(slbcu_pkg::OP_ALTERBIT, 32'h3, 32'h5, 32'h0, 32'h5);
        opc(slbcu_pkg::OP_CONCMPI, 32'h9, 32'h1, `SLBCU_CC_LESS);
        opd(slbcu_pkg::OP_CMPINCO, 32'h3, 32'h7, 32'h0, 32'h8);
        ccIs(`SLBCU_CC_LESS);
        opd(slbcu_pkg::OP_CMPDECO, 32'h7, 32'h7, 32'h0, 32'h6);
        ccIs(`SLBCU_CC_EQUAL);
        opd(slbcu_pkg::OP_CMPINCI, 32'hFFFFFFFF, 32'h1, 32'h0, 32'h2);
        ccIs(`SLBCU_CC_LESS);
        opd(slbcu_pkg::OP_CMPDECI, 32'h1, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFE);
        ccIs(`SLBCU_CC_GREATER);
    endtask
    // back-to-back compare and test, then every mask with both hints
    task automatic t_test;
        @(posedge sys_clk);
        cmd <= '{1'b1, slbcu_pkg::OP_CMPO, 32'h5, 32'h5, 32'h0, 3'h0, 1'b0};
        @(posedge sys_clk);
        cmd <= '{1'b1, slbcu_pkg::OP_TEST, 32'h0, 32'h0, 32'h0, 3'h2, 1'b0};
        @(posedge sys_clk);
        cmd.valid <= 1'b0;
        #1;
        chk("cmpWrEn", {31'h0, res.wrEn}, 32'h0);
        @(posedge sys_clk);
        #1;
        chk("testB2B", res.data, `SLBCU_TEST_TRUE);
        for (int m = 0; m < 8; m++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                op(slbcu_pkg::OP_TEST, 32'h0, 32'h0, 32'h0, m[2:0], p[0]);
                chk("test", res.data, (m != 0 && m[1]) ? `SLBCU_TEST_TRUE : `SLBCU_TEST_FALSE);
            end
        end
    endtask
    // ********************************
    // Main sequence and hang guard
    // ********************************
    initial
    begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        t_regs();
        t_shift();
        t_ovf();
        t_logic();
        t_bits();
        t_field();
        t_cmp();
        t_test();
        print_verdict();
    end
    // Bounded run: a stuck sequence still ends with a verdict
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("MISMATCH run length expected done seen still running");
        print_verdict();
    end
endmodule // tb_shift_logic_bit_compare_unit
`default_nettype wire
